/* hdl/serial_audio_input_port.sv */
/*
 Receive side of a three-wire serial audio input port: I2S, left- and
 right-justified and TDM framing, register port, halt handling.
 Assumes the host is clock master and the pins are asynchronous to core_clk.
*/
// Notes on behaviour
// - Three host-driven pins: bit clock, word clock or frame sync, serial data.
// - Serial data shifts into the shift register on core_clk at each synchronised bit clock rise while in PLAY.
// - Data is sampled on the bit clock rising edge.
// - Internal processing clocks derive from the bit clock; no master clock.
// - Sample rate is detected automatically: 32k, 44.1-48k, 88.2-96k classes.
// - Non-TDM formats: word clock 32 to 96 kHz, ratio 32 or 64.
// - Halted clocks or bad ratio set the clock fault status bit.
// - Clock halt puts processing to sleep and outputs to high impedance.
// - When clocks return the previous play state resumes by itself.
// - Configuration survives a clock halt; no reload needed.
// - Two-bit format field selects I2S, left, right justified or TDM.
// - Samples are two's complement, MSB first, up to 32 bits.
// - Word length is 24 bits after reset.
// - TDM frame starts at the frame sync rising edge.
// - I2S: word clock low is left, high is right.
// - Right-justified: word clock high is left, low is right.
// - TDM data offset of 0 or 1 bit clocks is supported.
`timescale 1ns/100ps
`default_nettype none
module serial_audio_input_port (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        bit_clk_in,
   input  wire logic        word_frame_sync,
   input  wire logic        serial_data_in,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   output logic      [31:0] left_sample,
   output logic      [31:0] right_sample,
   output logic             sample_valid,
   output logic      [1:0]  sample_rate,
   output logic             dsp_tick,
   output logic             dsp_sleep,
   output logic             amp_out_enable
);
   typedef enum {PLAY, SLEEP} power_t;

   audio_link_if link ();

   power_t                  power, next_power;
   logic [7:0]              fmt_ctrl, next_fmt_ctrl;
   logic [7:0]              tdm_ctrl, next_tdm_ctrl;
   logic [7:0]              next_rdata;
   logic [31:0]             shift, next_shift;
   logic [9:0]              pos, next_pos;
   logic [5:0]              bwc, next_bwc;
   logic [3:0]              widx, next_widx;
   logic                    ws_prev, next_ws_prev;
   logic [31:0]             next_left, next_right;
   logic                    next_valid, next_tick;
   audio_port_pkg::format_t fmt;
   logic [5:0]              wl;
   logic [9:0]              start;
   logic                    left_level, ws, boundary;
   logic [9:0]              cp;
   logic [5:0]              cb;
   logic [3:0]              cw;
   logic                    cap_en, cap_left;
   logic [31:0]             cap_word;

   // Pin sampling: bit clock, word clock / frame sync, data
   pin_sync_edges u_pins (
      .core_clk (core_clk),
      .rst      (rst),
      .pins_in  ({serial_data_in, word_frame_sync, bit_clk_in}),
      .link     (link.pins)
   );

   clock_monitor u_mon (
      .core_clk (core_clk),
      .rst      (rst),
      .link     (link.monitor)
   );

   // Decoded configuration
   assign fmt           = audio_port_pkg::format_t'(fmt_ctrl[audio_port_pkg::FMT_LSB +: 2]);
   assign wl            = audio_port_pkg::word_bits(
                             audio_port_pkg::word_len_t'(fmt_ctrl[audio_port_pkg::WL_LSB +: 2]));
   assign link.tdm_mode = (fmt == audio_port_pkg::FMT_TDM);
   assign ws            = link.wfs_level;
   // I2S puts left on low; left- and right-justified on high
   assign left_level    = (fmt != audio_port_pkg::FMT_I2S);
   // Bits skipped after a boundary before the MSB
   assign start         = (fmt == audio_port_pkg::FMT_I2S) ? 10'h001 :
                          (link.tdm_mode ? {9'h000, tdm_ctrl[audio_port_pkg::OFFSET_BIT]} : 10'h000);
   // TDM frames start on the sync rise only; other formats on either edge
   assign boundary      = link.tdm_mode ? (ws & ~ws_prev) : (ws ^ ws_prev);

   // Register port; configuration is not touched by clock loss
   always_comb begin
      next_fmt_ctrl = fmt_ctrl;
      next_tdm_ctrl = tdm_ctrl;
      next_rdata    = 8'h00;
      if (reg_write && reg_addr == audio_port_pkg::FORMAT_CTRL_ADDR) begin
         next_fmt_ctrl = reg_wdata;
      end
      if (reg_write && reg_addr == audio_port_pkg::TDM_CTRL_ADDR) begin
         next_tdm_ctrl = reg_wdata & audio_port_pkg::TDM_CTRL_MASK;
      end
      if (reg_read) begin
         unique case (reg_addr)
            audio_port_pkg::FORMAT_CTRL_ADDR:  next_rdata = fmt_ctrl;
            audio_port_pkg::TDM_CTRL_ADDR:     next_rdata = tdm_ctrl;
            audio_port_pkg::FAULT_STATUS_ADDR: next_rdata = {3'h0, link.rate, link.ratio_bad, link.halted,
                                                             link.halted | link.ratio_bad};
            default:                           next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fmt_ctrl  <= audio_port_pkg::FORMAT_CTRL_RESET;
         tdm_ctrl  <= audio_port_pkg::TDM_CTRL_RESET;
         reg_rdata <= 8'h00;
      end else begin
         fmt_ctrl  <= next_fmt_ctrl;
         tdm_ctrl  <= next_tdm_ctrl;
         reg_rdata <= next_rdata;
      end
   end

   // Sleep while clocks are halted, play again once a word clock rise clears the halt
   always_comb begin
      next_power = link.halted ? SLEEP : PLAY;
      // Processing rate follows the bit clock, twice per bit period
      next_tick  = (power == PLAY) && (link.bclk_rise || link.bclk_fall);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         power    <= SLEEP;
         dsp_tick <= 1'b0;
      end else begin
         power    <= next_power;
         dsp_tick <= next_tick;
      end
   end

   assign dsp_sleep      = (power == SLEEP);
   assign amp_out_enable = (power == PLAY);
   assign sample_rate    = link.rate;

   // Receive framing; every count restarts at a word or frame boundary
   always_comb begin
      next_ws_prev = ws_prev;
      next_shift   = shift;
      next_pos     = pos;
      next_bwc     = bwc;
      next_widx    = widx;
      next_left    = left_sample;
      next_right   = right_sample;
      next_valid   = 1'b0;
      cap_en       = 1'b0;
      cap_left     = 1'b0;
      cap_word     = 32'h00000000;
      cp           = boundary ? 10'h000 : pos;
      cb           = boundary ? 6'h00 : bwc;
      cw           = boundary ? 4'h0 : widx;
      if (link.bclk_rise && power == PLAY) begin
         next_ws_prev = ws;
         next_shift   = {shift[30:0], link.sdata};
         next_pos     = (cp == 10'h3FF) ? cp : cp + 10'h001;
         next_bwc     = cb;
         next_widx    = cw;
         if (fmt == audio_port_pkg::FMT_RIGHT_J) begin
            // The word ends just before the edge, so it is taken at the edge
            if (boundary) begin
               cap_en   = 1'b1;
               cap_word = shift;
               cap_left = (ws_prev == 1'b1);
            end
         end else if (cp >= start) begin
            if (cb == 6'(wl - 6'h01)) begin
               next_bwc  = 6'h00;
               next_widx = (cw == 4'hF) ? cw : cw + 4'h1;
               cap_en    = link.tdm_mode ? (cw <= 4'h1) : (cw == 4'h0);
               cap_word  = next_shift;
               cap_left  = link.tdm_mode ? (cw == 4'h0) : (ws == left_level);
            end else begin
               next_bwc = cb + 6'h01;
            end
         end
      end
      // Left-align so the sign bit lands on bit 31
      if (cap_en) begin
         if (cap_left) begin
            next_left = cap_word << (6'h20 - wl);
         end else begin
            next_right = cap_word << (6'h20 - wl);
            next_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ws_prev      <= 1'b0;
         shift        <= 32'h00000000;
         pos          <= 10'h000;
         bwc          <= 6'h00;
         widx         <= 4'h0;
         left_sample  <= 32'h00000000;
         right_sample <= 32'h00000000;
         sample_valid <= 1'b0;
      end else begin
         ws_prev      <= next_ws_prev;
         shift        <= next_shift;
         pos          <= next_pos;
         bwc          <= next_bwc;
         widx         <= next_widx;
         left_sample  <= next_left;
         right_sample <= next_right;
         sample_valid <= next_valid;
      end
   end

   // TDM frame start as seen by the receiver
   sequence frame_start_s;
      link.bclk_rise && link.tdm_mode && power == PLAY && ws && !ws_prev;
   endsequence

   // Clock halt exit
   sequence halt_end_s;
      $fell(link.halted);
   endsequence

   tdm_frame_a: assert property (@(posedge core_clk) disable iff (rst)
      frame_start_s |=> pos == 10'h001) else $error("frame start did not restart bit position");
   tdm_offset_a: assert property (@(posedge core_clk) disable iff (rst)
      frame_start_s |=> bwc == (tdm_ctrl[audio_port_pkg::OFFSET_BIT] ? 6'h00 : 6'h01))
      else $error("tdm offset not honoured");
   sample_rise_a: assert property (@(posedge core_clk) disable iff (rst)
      link.bclk_rise && power == PLAY |=> shift[0] == $past(link.sdata)) else $error("data not sampled at rise");
   out_hiz_a: assert property (@(posedge core_clk) disable iff (rst)
      link.halted |=> !amp_out_enable && dsp_sleep) else $error("outputs driven while halted");
   auto_resume_a: assert property (@(posedge core_clk) disable iff (rst)
      halt_end_s |=> amp_out_enable && !dsp_sleep) else $error("no resume after clocks return");
   fault_read_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_read && reg_addr == audio_port_pkg::FAULT_STATUS_ADDR && (link.halted || link.ratio_bad)
      |=> reg_rdata[audio_port_pkg::ST_FAULT_BIT]) else $error("clock fault not reported");
   fmt_write_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_write && reg_addr == audio_port_pkg::FORMAT_CTRL_ADDR |=> fmt_ctrl == $past(reg_wdata))
      else $error("format write lost");
   wl_reset_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(rst) |-> wl == 6'h18) else $error("word length not 24 after reset");
   i2s_chan_a: assert property (@(posedge core_clk) disable iff (rst)
      cap_en && fmt == audio_port_pkg::FMT_I2S && !ws |-> cap_left) else $error("i2s low half not left");
   config_kept_a: assert property (@(posedge core_clk) disable iff (rst)
      link.halted && !reg_write |=> $stable(fmt_ctrl) && $stable(tdm_ctrl)) else $error("config lost in halt");
endmodule // serial_audio_input_port
`default_nettype wire

/* hdl/audio_port_pkg.sv */
/*
 Shared constants and types for the serial audio input port: register
 offsets, field positions, reset values, formats and timing counts.
 Assumes a 40 MHz core clock.
*/
package audio_port_pkg;

   // Core clock period
   localparam int CLK_PERIOD_NS = 25;

   // Register offsets
   localparam logic [7:0] FORMAT_CTRL_ADDR  = 8'h33;
   localparam logic [7:0] TDM_CTRL_ADDR     = 8'h34;
   localparam logic [7:0] FAULT_STATUS_ADDR = 8'h71;

   // Format control fields
   localparam int FMT_LSB  = 4;
   localparam int SYNC_LSB = 2;
   localparam int WL_LSB   = 0;
   localparam logic [7:0] FORMAT_CTRL_RESET = 8'h02;   // I2S, normal sync, 24-bit words
   localparam logic [7:0] TDM_CTRL_RESET    = 8'h00;
   localparam logic [7:0] TDM_CTRL_MASK     = 8'h01;
   localparam int OFFSET_BIT = 0;

   // Fault status fields
   localparam int ST_FAULT_BIT = 0;
   localparam int ST_HALT_BIT  = 1;
   localparam int ST_RATIO_BIT = 2;
   localparam int ST_RATE_LSB  = 3;

   typedef enum logic [1:0] {FMT_I2S, FMT_LEFT_J, FMT_RIGHT_J, FMT_TDM} format_t;
   typedef enum logic [1:0] {WL_16, WL_20, WL_24, WL_32} word_len_t;
   typedef enum logic [1:0] {RATE_NONE, RATE_32K, RATE_48K, RATE_96K} rate_t;

   // Clock supervision times and their cycle counts
   localparam int HALT_TIME_NS      = 5000;
   localparam int FRAME_TIMEOUT_NS  = 50000;
   localparam int RATE_32K_MIN_NS   = 27000;
   localparam int RATE_48K_MIN_NS   = 14000;
   localparam int RATE_96K_MIN_NS   = 9000;
   localparam logic [11:0] HALT_CYC      = 12'(HALT_TIME_NS / CLK_PERIOD_NS);
   localparam logic [11:0] FRAME_TO_CYC  = 12'(FRAME_TIMEOUT_NS / CLK_PERIOD_NS);
   localparam logic [11:0] RATE_32K_CYC  = 12'(RATE_32K_MIN_NS / CLK_PERIOD_NS);
   localparam logic [11:0] RATE_48K_CYC  = 12'(RATE_48K_MIN_NS / CLK_PERIOD_NS);
   localparam logic [11:0] RATE_96K_CYC  = 12'(RATE_96K_MIN_NS / CLK_PERIOD_NS);

   // Bit clocks per frame
   localparam logic [9:0] RATIO_32  = 10'h020;
   localparam logic [9:0] RATIO_64  = 10'h040;
   localparam logic [9:0] RATIO_128 = 10'h080;
   localparam logic [9:0] RATIO_256 = 10'h100;
   localparam logic [9:0] RATIO_512 = 10'h200;

   // Word length code to bit count
   function automatic logic [5:0] word_bits(word_len_t w);
      unique case (w)
         WL_16:   word_bits = 6'h10;
         WL_20:   word_bits = 6'h14;
         WL_24:   word_bits = 6'h18;
         WL_32:   word_bits = 6'h20;
      endcase
   endfunction

endpackage

/* hdl/audio_link_if.sv */
/*
 Carrier between the pin sampler, the clock monitor and the receive core.
 Assumes all members change on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface audio_link_if;
   logic                  bclk_rise;
   logic                  bclk_fall;
   logic                  wfs_level;
   logic                  wfs_rise;
   logic                  sdata;
   logic                  tdm_mode;
   logic                  halted;
   logic                  ratio_bad;
   audio_port_pkg::rate_t rate;

   modport pins    (output bclk_rise, bclk_fall, wfs_level, wfs_rise, sdata);
   modport monitor (input bclk_rise, wfs_rise, tdm_mode, output halted, ratio_bad, rate);
   modport core    (input bclk_rise, bclk_fall, wfs_level, sdata, halted, ratio_bad, rate,
                    output tdm_mode);
endinterface
`default_nettype wire

/* hdl/pin_sync_edges.sv */
/*
 Two-flop synchronisers for the three audio pins plus edge detection.
 Assumes the pins are asynchronous to core_clk and much slower than it.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sync_edges (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [2:0] pins_in,
   audio_link_if.pins      link
);
   logic [2:0] meta;
   logic [2:0] stable;
   logic [2:0] delayed;

   // One chain per pin; only the second stage and later feed logic
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            meta[i]    <= 1'b0;
            stable[i]  <= 1'b0;
            delayed[i] <= 1'b0;
         end else begin
            meta[i]    <= pins_in[i];
            stable[i]  <= meta[i];
            delayed[i] <= stable[i];
         end
      end
   end

   // Data shares the clock's latency, so it lines up with the rising edge
   assign link.bclk_rise = stable[0] & ~delayed[0];
   assign link.bclk_fall = ~stable[0] & delayed[0];
   assign link.wfs_level = stable[1];
   assign link.wfs_rise  = stable[1] & ~delayed[1];
   assign link.sdata     = stable[2];
endmodule // pin_sync_edges
`default_nettype wire

/* hdl/clock_monitor.sv */
/*
 Watches the synchronised bit clock and word clock: halt detection,
 sample rate class and bit-clock-per-frame ratio check.
 Assumes edge pulses from the pin sampler on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module clock_monitor (
   input  wire logic core_clk,
   input  wire logic rst,
   audio_link_if.monitor link
);
   logic [11:0]           idle_cnt,  next_idle_cnt;
   logic [11:0]           frame_cyc, next_frame_cyc;
   logic [9:0]            bit_cnt,   next_bit_cnt;
   logic                  halted,    next_halted;
   logic                  ratio_bad, next_ratio_bad;
   audio_port_pkg::rate_t rate,      next_rate;
   audio_port_pkg::rate_t meas_rate;
   logic                  ratio_ok;

   // Sample rate class from frame length, and ratio legality per format
   always_comb begin
      meas_rate = audio_port_pkg::RATE_NONE;
      ratio_ok  = 1'b0;
      if (frame_cyc >= audio_port_pkg::RATE_32K_CYC) begin
         meas_rate = audio_port_pkg::RATE_32K;
      end else if (frame_cyc >= audio_port_pkg::RATE_48K_CYC) begin
         meas_rate = audio_port_pkg::RATE_48K;
      end else if (frame_cyc >= audio_port_pkg::RATE_96K_CYC) begin
         meas_rate = audio_port_pkg::RATE_96K;
      end
      if (!link.tdm_mode) begin
         ratio_ok = (bit_cnt == audio_port_pkg::RATIO_32) || (bit_cnt == audio_port_pkg::RATIO_64);
      end else begin
         unique case (meas_rate)
            audio_port_pkg::RATE_32K: ratio_ok = (bit_cnt == audio_port_pkg::RATIO_128);
            audio_port_pkg::RATE_48K: ratio_ok = (bit_cnt == audio_port_pkg::RATIO_128) ||
                                                 (bit_cnt == audio_port_pkg::RATIO_256) ||
                                                 (bit_cnt == audio_port_pkg::RATIO_512);
            audio_port_pkg::RATE_96K: ratio_ok = (bit_cnt == audio_port_pkg::RATIO_128) ||
                                                 (bit_cnt == audio_port_pkg::RATIO_256);
            audio_port_pkg::RATE_NONE: ratio_ok = 1'b0;
         endcase
      end
   end

   // Counters and verdicts; a frame is judged only while clocks run
   always_comb begin
      next_idle_cnt  = link.bclk_rise ? 12'h000 : ((idle_cnt == 12'hFFF) ? idle_cnt : idle_cnt + 12'h001);
      next_frame_cyc = link.wfs_rise ? 12'h000 : ((frame_cyc == 12'hFFF) ? frame_cyc : frame_cyc + 12'h001);
      next_bit_cnt   = bit_cnt;
      if (link.wfs_rise) begin
         next_bit_cnt = 10'h000;
      end else if (link.bclk_rise && bit_cnt != 10'h3FF) begin
         next_bit_cnt = bit_cnt + 10'h001;
      end
      next_halted    = halted;
      next_ratio_bad = ratio_bad;
      next_rate      = rate;
      if (idle_cnt >= audio_port_pkg::HALT_CYC || frame_cyc >= audio_port_pkg::FRAME_TO_CYC) begin
         next_halted = 1'b1;
      end else if (link.wfs_rise) begin
         next_halted = 1'b0;
         if (!halted) begin
            next_rate      = meas_rate;
            next_ratio_bad = !ratio_ok || meas_rate == audio_port_pkg::RATE_NONE;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         idle_cnt  <= 12'h000;
         frame_cyc <= 12'h000;
         bit_cnt   <= 10'h000;
         halted    <= 1'b1;
         ratio_bad <= 1'b0;
         rate      <= audio_port_pkg::RATE_NONE;
      end else begin
         idle_cnt  <= next_idle_cnt;
         frame_cyc <= next_frame_cyc;
         bit_cnt   <= next_bit_cnt;
         halted    <= next_halted;
         ratio_bad <= next_ratio_bad;
         rate      <= next_rate;
      end
   end

   assign link.halted    = halted;
   assign link.ratio_bad = ratio_bad;
   assign link.rate      = rate;
endmodule // clock_monitor
`default_nettype wire

/* verif/audio_host_model.sv */
/*
 Behavioural host that is clock master of the serial audio port.
 Assumes a 200 ns bit clock, 64 bit clocks per frame (128 in TDM), data changed on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module audio_host_model (
   input  wire logic        run,
   input  wire logic        delay1,
   input  wire logic        left_high,
   input  wire logic        tdm,
   input  wire logic [31:0] lword,
   input  wire logic [31:0] rword,
   output logic             bclk,
   output logic             wfs,
   output logic             sdata
);
   logic [31:0] w;
   int          k;
   // Whole frames only; the clocks stand still while run is low
   initial begin
      bclk = 1'b0;
      wfs = 1'b0;
      sdata = 1'b0;
      forever begin
         if (!run) begin
            sdata = ~sdata; // Idle data line keeps moving so no stale bit is mistaken for data
            #100;
         end else if (tdm) begin
            // Slot 0 left, slot 1 right, 32-bit slots, rest of the frame filler
            for (int j = 0; j < 128; j++) begin
               bclk = 1'b0;
               wfs = (j == 0); // sync high for one bit clock only
               k = j - int'(delay1);
               sdata = (k >= 0 && k < 32) ? lword[31 - k] : ((k >= 32 && k < 64) ? rword[63 - k] : ~sdata);
               #100 bclk = 1'b1;
               #100;
            end
         end else begin
            for (int h = 0; h < 2; h++) begin
               for (int i = 0; i < 32; i++) begin
                  bclk = 1'b0;
                  if (i == 0) wfs = (h == 0) ~^ left_high;
                  w = h ? rword : lword;
                  sdata = (i >= delay1) ? w[5'(31 + delay1 - i)] : ~sdata;
                  #100 bclk = 1'b1;
                  #100;
               end
            end
         end
      end
   end
endmodule // audio_host_model
`default_nettype wire

/* verif/tb.sv */
/*
 Self-checking bench for the serial audio input port.
 Assumes the host model above on the pins and the plain register port.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        core_clk, rst, run, delay1, left_high, tdm, bclk, wfs, sdata;
   logic        reg_write, reg_read, sample_valid, dsp_tick, dsp_sleep, amp_out_enable;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [31:0] lword, rword, left_sample, right_sample;
   logic [1:0]  sample_rate;
   int          bad_count, checked;

   audio_host_model host (.run(run), .delay1(delay1), .left_high(left_high), .tdm(tdm), .lword(lword),
      .rword(rword), .bclk(bclk), .wfs(wfs), .sdata(sdata));
   serial_audio_input_port dut (.core_clk(core_clk), .rst(rst), .bit_clk_in(bclk),
      .word_frame_sync(wfs), .serial_data_in(sdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .left_sample(left_sample),
      .right_sample(right_sample), .sample_valid(sample_valid), .sample_rate(sample_rate),
      .dsp_tick(dsp_tick), .dsp_sleep(dsp_sleep), .amp_out_enable(amp_out_enable));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic end_of_test;
      $display("Checks %0d, errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a; reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Bounded wait for n word pairs; the first may be partial
   task automatic words(input int n);
      int k;
      k = 0;
      repeat (40000) begin
         @(posedge core_clk);
         #1 if (sample_valid === 1'b1) k++;
         if (k == n) break;
      end
      if (k < n) chk("sample_valid count", n, k);
   endtask

   task automatic t_reset;
      logic [7:0] d;
      rd(8'h33, d); chk("format ctrl", 32'h02, d);
      rd(8'h34, d); chk("tdm ctrl", 32'h00, d);
      rd(8'h40, d); chk("unmapped", 32'h00, d);
      rd(8'h71, d); chk("status halt", 32'h3, d[1:0]);
      chk("amp enable", 32'h0, amp_out_enable);
   endtask

   // Four word pairs in the new format are waited for, so the rate and ratio verdicts are settled
   task automatic t_stream(input logic [7:0] fmt, input logic dly, input logic hi, input logic tdm_on,
                           input logic [31:0] mask, input logic [1:0] rt);
      logic [7:0] d;
      int         n;
      wr(8'h33, fmt);
      wr(8'h34, {7'h00, dly});
      delay1 <= dly; left_high <= hi; tdm <= tdm_on; run <= 1'b1;
      words(4);
      chk("left_sample", lword & mask, left_sample);
      chk("right_sample", rword & mask, right_sample);
      chk("amp enable", 32'h1, amp_out_enable);
      chk("sample rate", 32'(rt), sample_rate);
      rd(8'h71, d); chk("status fault", 32'h0, d[0]);
      n = 0;
      repeat (16) begin
         @(posedge core_clk);
         #1 if (dsp_tick === 1'b1) n++;
      end
      chk("dsp ticks", 32'h4, n);
   endtask

   task automatic t_halt;
      logic [7:0] d;
      run <= 1'b0;
      repeat (900) @(posedge core_clk);
      #1 chk("amp enable", 32'h0, amp_out_enable);
      chk("dsp tick", 32'h0, dsp_tick);
      chk("dsp sleep", 32'h1, dsp_sleep);
      rd(8'h71, d); chk("status halt", 32'h3, d[1:0]);
      rd(8'h33, d); chk("format kept", 32'h12, d);
      run <= 1'b1; // Clocks stood still far beyond the halt limit
      words(3);
      chk("amp enable", 32'h1, amp_out_enable);
      chk("left_sample", {lword[31:8], 8'h00}, left_sample);
   endtask

   initial begin
      rst = 1'b1; run = 1'b0; delay1 = 1'b1; left_high = 1'b0; tdm = 1'b0;
      lword = 32'hA5C3E17F; rword = 32'h12345678;
      reg_addr = 8'h00; reg_wdata = 8'h00; reg_write = 1'b0; reg_read = 1'b0;
      bad_count = 0; checked = 0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      t_reset;
      t_stream(8'h02, 1'b1, 1'b0, 1'b0, 32'hFFFFFF00, 2'h3);
      lword <= 32'h7F0081FF; rword <= 32'h80FF3C01;
      t_stream(8'h12, 1'b0, 1'b1, 1'b0, 32'hFFFFFF00, 2'h3);
      t_halt;
      t_stream(8'h23, 1'b0, 1'b1, 1'b0, 32'hFFFFFFFF, 2'h3);
      t_stream(8'h37, 1'b1, 1'b0, 1'b1, 32'hFFFFFFFF, 2'h2);
      end_of_test;
   end

   // Whole run is near 320 us; a hang is cut off well after that
   initial begin
      #2000000;
      bad_count++;
      end_of_test;
   end
endmodule // tb
`default_nettype wire
